// ---- twp_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "twp_map.svh"
module twp_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // drawing-engine fifo write port
  input wire logic wr_en,
  input wire logic [13:0] wr_addr,
  input wire logic [31:0] wr_data,
  // scan engine control
  input wire logic span_start,
  input wire logic pixel_step,
  input wire logic span_end,
  input wire logic clamp_mode,
  // pixel walk values
  output logic signed [31:0] s_pix_q,
  output logic signed [31:0] t_pix_q,
  output logic signed [31:0] q_pix_q,
  // texel column and q exception
  output logic [10:0] texel_col_q,
  output logic q_exception_q,
  // width configuration fields
  output logic signed [5:0] texture_width_log_q,
  output logic signed [5:0] width_roundup_factor_q,
  output logic [10:0] width_wrap_mask_q,
  // sequencer status
  output logic busy_q
);
  // ----------------------------------------
  // parameter registers
  // ----------------------------------------
  logic signed [31:0] s_step_x_q, s_step_y_q, t_step_x_q, t_step_y_q;
  logic signed [31:0] q_step_x_q, q_step_y_q;
  twp_pkg::twp_state_t state_q;
  logic [1:0] line_idx_q;
  logic [31:0] acc_rd;

  // increments only change on software writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_step_x_q <= `TWP_RST_WORD;
      s_step_y_q <= `TWP_RST_WORD;
      t_step_x_q <= `TWP_RST_WORD;
      t_step_y_q <= `TWP_RST_WORD;
      q_step_x_q <= `TWP_RST_WORD;
      q_step_y_q <= `TWP_RST_WORD;
    end else if (ce && wr_en) begin
      unique case (wr_addr)
        `TWP_OFS_S_STEP_X: s_step_x_q <= wr_data;
        `TWP_OFS_S_STEP_Y: s_step_y_q <= wr_data;
        `TWP_OFS_T_STEP_X: t_step_x_q <= wr_data;
        `TWP_OFS_T_STEP_Y: t_step_y_q <= wr_data;
        `TWP_OFS_Q_STEP_X: q_step_x_q <= wr_data;
        `TWP_OFS_Q_STEP_Y: q_step_y_q <= wr_data;
        default: ;
      endcase
    end
  end

  // width config; reserved bits are simply not stored
  // the signed fields are kept raw; their meaning belongs to the texel unit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      texture_width_log_q <= '0;
      width_roundup_factor_q <= '0;
      width_wrap_mask_q <= '0;
    end else if (ce && wr_en && wr_addr == `TWP_OFS_TW_CFG) begin
      texture_width_log_q <= wr_data[`TWP_TWLOG_MSB:`TWP_TWLOG_LSB];
      width_roundup_factor_q <= wr_data[`TWP_RFW_MSB:`TWP_RFW_LSB];
      width_wrap_mask_q <= wr_data[`TWP_TWMASK_MSB:`TWP_TWMASK_LSB];
    end
  end

  // ----------------------------------------
  // left-edge accumulators
  // ----------------------------------------
  // a software edge write wins over the scan update to any word
  // limitation: the skipped scan step is lost, so load starts before span_start
  logic acc_sw;
  logic [1:0] acc_sw_addr;
  logic acc_we;
  logic [1:0] acc_waddr;
  logic [31:0] acc_wdata;

  always_comb begin
    acc_sw = 1'b0;
    acc_sw_addr = 2'h3;
    if (wr_en) begin
      unique case (wr_addr)
        `TWP_OFS_S_EDGE: begin acc_sw = 1'b1; acc_sw_addr = 2'h0; end
        `TWP_OFS_T_EDGE: begin acc_sw = 1'b1; acc_sw_addr = 2'h1; end
        `TWP_OFS_Q_EDGE: begin acc_sw = 1'b1; acc_sw_addr = 2'h2; end
        default: ;
      endcase
    end
  end

  // y increment for the accumulator being walked
  function automatic logic [31:0] step_y(input logic [1:0] idx, input logic [31:0] sy,
                                          input logic [31:0] ty, input logic [31:0] qy);
    step_y = (idx == 2'h0) ? sy : (idx == 2'h1) ? ty : qy;
  endfunction : step_y

  // read data of index line_idx_q appears one cycle after it is presented
  always_comb begin
    acc_we = acc_sw;
    acc_waddr = acc_sw_addr;
    acc_wdata = wr_data;
    if (!acc_sw && state_q == twp_pkg::TWP_LINE && line_idx_q != 2'h0) begin
      acc_we = 1'b1;
      acc_waddr = line_idx_q - 2'h1;
      acc_wdata = acc_rd + step_y(acc_waddr, s_step_y_q, t_step_y_q, q_step_y_q);
    end
  end

  twp_acc_bank #(.W(32)) u_acc (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .we(acc_we),
    .waddr(acc_waddr),
    .wdata(acc_wdata),
    .raddr(line_idx_q),
    .rdata_q(acc_rd)
  );

  // ----------------------------------------
  // scan sequencer
  // ----------------------------------------
  // LINE walks indices 0..3: reads lead writes by one cycle
  // index 0 only primes the read port; 1..3 write s, t and q back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= twp_pkg::TWP_IDLE;
      line_idx_q <= 2'h0;
    end else if (ce) begin
      unique case (state_q)
        twp_pkg::TWP_IDLE: begin
          line_idx_q <= 2'h0;
          if (span_start) state_q <= twp_pkg::TWP_LINE;
        end
        twp_pkg::TWP_LINE: begin
          line_idx_q <= line_idx_q + 2'h1;
          if (line_idx_q == 2'h3) state_q <= twp_pkg::TWP_PIXEL;
        end
        twp_pkg::TWP_PIXEL: begin
          line_idx_q <= 2'h0;
          if (span_end) state_q <= twp_pkg::TWP_IDLE;
        end
        default: state_q <= twp_pkg::TWP_IDLE;
      endcase
    end
  end

  // pixel values: loaded from the stepped edge, then walked by x steps
  // the x steps are only read here; a software write can still change them during a span
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_pix_q <= `TWP_RST_WORD;
      t_pix_q <= `TWP_RST_WORD;
      q_pix_q <= `TWP_RST_WORD;
    end else if (ce) begin
      if (acc_we && !acc_sw) begin
        unique case (acc_waddr)
          2'h0: s_pix_q <= acc_wdata;
          2'h1: t_pix_q <= acc_wdata;
          default: q_pix_q <= acc_wdata;
        endcase
      end else if (state_q == twp_pkg::TWP_PIXEL && pixel_step) begin
        s_pix_q <= s_pix_q + s_step_x_q;
        t_pix_q <= t_pix_q + t_step_x_q;
        q_pix_q <= q_pix_q + q_step_x_q;
      end
    end
  end

  // ----------------------------------------
  // texel column and status
  // ----------------------------------------
  // texel column wrap or clamp; in clamp mode negative columns clamp to zero
  // repeat only wraps cleanly when the mask is all ones below its top bit
  logic signed [11:0] col_int;
  logic [10:0] col_next;
  always_comb begin
    col_int = s_pix_q[`TWP_ST_FRAC+11:`TWP_ST_FRAC];
    if (!clamp_mode) col_next = col_int[10:0] & width_wrap_mask_q;
    else if (col_int < 0) col_next = 11'h000;
    else if (col_int[10:0] > width_wrap_mask_q) col_next = width_wrap_mask_q;
    else col_next = col_int[10:0];
  end

  // column, exception and busy flags
  // all three are registered, so each trails its source by one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      texel_col_q <= 11'h000;
      q_exception_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (ce) begin
      texel_col_q <= col_next;
      q_exception_q <= (q_pix_q <= 0);
      busy_q <= (state_q != twp_pkg::TWP_IDLE);
    end
  end
endmodule : twp_regs
`default_nettype wire

// ---- twp_map.svh ----
`ifndef TWP_MAP_SVH
`define TWP_MAP_SVH
// register word offsets inside the drawing-engine window
`define TWP_OFS_S_STEP_X 14'h2C00
`define TWP_OFS_S_STEP_Y 14'h2C04
`define TWP_OFS_T_STEP_X 14'h2C08
`define TWP_OFS_T_STEP_Y 14'h2C0C
`define TWP_OFS_Q_STEP_X 14'h2C10
`define TWP_OFS_Q_STEP_Y 14'h2C14
`define TWP_OFS_S_EDGE 14'h2C18
`define TWP_OFS_T_EDGE 14'h2C1C
`define TWP_OFS_Q_EDGE 14'h2C20
`define TWP_OFS_TW_CFG 14'h2C28
// texture width configuration fields
`define TWP_TWLOG_LSB 0
`define TWP_TWLOG_MSB 5
`define TWP_RFW_LSB 9
`define TWP_RFW_MSB 14
`define TWP_TWMASK_LSB 18
`define TWP_TWMASK_MSB 28
// accumulator integer part starts here (12.20 and 16.16)
`define TWP_ST_FRAC 20
`define TWP_Q_FRAC 16
// reset value of all parameter words (documented as unknown)
`define TWP_RST_WORD 32'h0000_0000
`endif

// ---- twp_pkg.sv ----
`default_nettype none
package twp_pkg;
  // scan engine states
  typedef enum logic [2:0] {
    TWP_IDLE = 3'b001,
    TWP_PIXEL = 3'b010,
    TWP_LINE = 3'b100
  } twp_state_t;
endpackage : twp_pkg
`default_nettype wire

// ---- twp_acc_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "twp_map.svh"
// three-word accumulator memory: index 0 = s, 1 = t, 2 = q
module twp_acc_bank #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [1:0] raddr,
  output logic [W-1:0] rdata_q
);
  logic [W-1:0] mem_q [0:2];

  // storage words
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 3; i++) mem_q[i] <= `TWP_RST_WORD;
    end else if (ce && we && waddr != 2'h3) begin
      mem_q[waddr] <= wdata;
    end
  end

  // registered read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= `TWP_RST_WORD;
    end else if (ce) begin
      rdata_q <= (raddr == 2'h3) ? `TWP_RST_WORD : mem_q[raddr];
    end
  end
endmodule : twp_acc_bank
`default_nettype wire

// ---- twp_regs_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---
// port checker
// ---
module twp_regs_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host side
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [13:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic clamp_mode,
  // outputs
  input wire logic signed [31:0] s_pix_q,
  input wire logic signed [31:0] q_pix_q,
  input wire logic [10:0] texel_col_q,
  input wire logic q_exception_q,
  input wire logic signed [5:0] texture_width_log_q,
  input wire logic signed [5:0] width_roundup_factor_q,
  input wire logic [10:0] width_wrap_mask_q
);
  logic cw;
  logic [10:0] cc;
  // config write taken at this edge
  assign cw = ce && wr_en && wr_addr == 14'h2C28;
  // expected column: a negative s clamps to zero, not to the mask
  assign cc = !clamp_mode ? s_pix_q[30:20] & width_wrap_mask_q :
    s_pix_q[31] ? 11'h000 : s_pix_q[31:20] > {1'b0, width_wrap_mask_q} ?
    width_wrap_mask_q : s_pix_q[30:20];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_twlog_load:
    assert property (cw |=> texture_width_log_q == $past(wr_data[5:0])) else $error("log");
  a_round_load:
    assert property (cw |=> width_roundup_factor_q == $past(wr_data[14:9])) else $error("rfw");
  a_mask_load:
    assert property (cw |=> width_wrap_mask_q == $past(wr_data[28:18])) else $error("mask");
  a_cfg_hold:
    assert property (!cw |=> $stable(texture_width_log_q)) else $error("log hold");
  a_mask_hold:
    assert property (!cw |=> $stable(width_wrap_mask_q)) else $error("mask hold");
  a_col_map:
    assert property (ce |=> texel_col_q == $past(cc)) else $error("column");
  a_q_exc:
    assert property (ce |=> q_exception_q == ($past(q_pix_q) <= 0)) else $error("q exc");
  a_ce_freeze:
    assert property (!ce |=> $stable(s_pix_q) && $stable(texel_col_q)) else $error("freeze");
  // main scenarios
  c_cfg: cover property (cw);
  c_clamp: cover property (clamp_mode && texel_col_q == width_wrap_mask_q);
  c_exc: cover property (q_exception_q);
endmodule : twp_regs_checker
bind twp_regs twp_regs_checker chk_u (.clk(clk), .rstn(rstn), .ce(ce), .wr_en(wr_en),
  .wr_addr(wr_addr), .wr_data(wr_data), .clamp_mode(clamp_mode), .s_pix_q(s_pix_q),
  .q_pix_q(q_pix_q), .texel_col_q(texel_col_q), .q_exception_q(q_exception_q),
  .texture_width_log_q(texture_width_log_q),
  .width_roundup_factor_q(width_roundup_factor_q), .width_wrap_mask_q(width_wrap_mask_q));
`default_nettype wire

// ---- tb_twp_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_twp_regs;
  logic clk, rstn, ce, wr_en, span_start, pixel_step, span_end, clamp_mode;
  logic [13:0] wr_addr;
  logic [31:0] wr_data, rnd, d, ps, pt, pq;
  logic [31:0] v [9];
  logic signed [31:0] s_pix_q, t_pix_q, q_pix_q;
  logic [10:0] width_wrap_mask_q, texel_col_q;
  logic q_exception_q, busy_q;
  logic signed [5:0] texture_width_log_q, width_roundup_factor_q;
  int n_errors, check_count, n;
  twp_regs dut_u (.clk(clk), .rstn(rstn), .ce(ce), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .span_start(span_start), .pixel_step(pixel_step),
    .span_end(span_end), .clamp_mode(clamp_mode), .s_pix_q(s_pix_q), .t_pix_q(t_pix_q),
    .q_pix_q(q_pix_q), .texel_col_q(texel_col_q), .q_exception_q(q_exception_q),
    .busy_q(busy_q),
    .texture_width_log_q(texture_width_log_q),
    .width_roundup_factor_q(width_roundup_factor_q), .width_wrap_mask_q(width_wrap_mask_q));
  // ---
  // helpers
  // ---
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nx
  // value after k increments
  function automatic logic [31:0] walk(input logic [31:0] b, input logic [31:0] st, input int k);
    return b + st * k;
  endfunction : walk
  // expected texel column: repeat masks, clamp pins to zero or to the mask
  function automatic logic [10:0] col_exp(input logic [31:0] s, input logic [10:0] m,
                                          input logic c);
    if (!c) return s[30:20] & m;
    if (s[31]) return 11'h000;
    if (s[30:20] > m) return m;
    return s[30:20];
  endfunction : col_exp
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [13:0] a, input logic [31:0] x);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= x;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // close any span, start a scanline, let the edge walk finish
  task automatic line();
    @(posedge clk);
    span_end <= 1'b1;
    @(posedge clk);
    span_end <= 1'b0;
    span_start <= 1'b1;
    @(posedge clk);
    span_start <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask : line
  task automatic results();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ---
  // main sequence
  // ---
  initial begin
    {rstn, ce, wr_en, span_start, pixel_step, span_end, clamp_mode} = 7'h00;
    wr_addr = 14'h0000;
    wr_data = 32'h0;
    rnd = 32'h0455;
    n_errors = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    ce <= 1'b1;
    // all fields set, all clear, then random; an unmapped write must not disturb them
    for (int i = 0; i < 6; i++) begin
      rnd = nx(rnd);
      d = (i == 0) ? 32'h1FFC7E3F : (i == 1) ? 32'h0 : rnd & 32'h1FFC7E3F;
      wr(14'h2C28, d);
      wr(i[0] ? 14'h2C2C : 14'h2C24, ~d);
      @(negedge clk);
      chk("twlog", d[5:0], $unsigned(texture_width_log_q));
      chk("rfw", d[14:9], $unsigned(width_roundup_factor_q));
      chk("twmask", d[28:18], width_wrap_mask_q);
    end
    chk("busy_idle", 32'h0, 32'(busy_q));
    // steps and edge starts; the q start is kept positive
    for (int i = 0; i < 9; i++) begin
      rnd = nx(rnd);
      v[i] = (i == 8) ? {1'b0, rnd[30:0]} : rnd;
      wr(14'h2C00 + 14'(4 * i), v[i]);
    end
    line();
    chk("busy_scan", 32'h1, 32'(busy_q));
    ps = s_pix_q;
    pt = t_pix_q;
    pq = q_pix_q;
    n = 0;
    // pixel run with the clock enable dropping at random
    repeat (12) begin
      @(posedge clk);
      rnd = nx(rnd);
      ce <= rnd[0];
      clamp_mode <= rnd[1];
      pixel_step <= 1'b1;
      n += rnd[0];
    end
    @(posedge clk);
    ce <= 1'b1;
    pixel_step <= 1'b0;
    @(negedge clk);
    chk("s_x", walk(ps, v[0], n), s_pix_q);
    chk("t_x", walk(pt, v[2], n), t_pix_q);
    chk("q_x", walk(pq, v[4], n), q_pix_q);
    line();
    chk("s_y", walk(ps, v[1], 1), s_pix_q);
    chk("t_y", walk(pt, v[3], 1), t_pix_q);
    chk("q_y", walk(pq, v[5], 1), q_pix_q);
    // zero y steps so the next line shows the new starts unchanged
    for (int i = 1; i < 9; i++) begin
      rnd = nx(rnd);
      v[i] = (i[0] && i < 6) ? 32'h0 : (i == 8) ? {1'b0, rnd[30:0]} : rnd;
      wr(14'h2C00 + 14'(4 * i), v[i]);
    end
    line();
    chk("s_acc", v[6], s_pix_q);
    chk("t_acc", v[7], t_pix_q);
    chk("q_acc", v[8], q_pix_q);
    chk("col", col_exp(v[6], d[28:18], clamp_mode), texel_col_q);
    chk("q_exc", 32'($signed(v[8]) <= 0), 32'(q_exception_q));
    results();
  end
endmodule : tb_twp_regs
`default_nettype wire
